// [hw/lvdc_top.sv]
// low-voltage detector control, flags and AXI4-Lite register slave
`default_nettype none
// Notes on behaviour
// - control bit 0 reads the inverted synchronised comparator result (1 = below threshold) while enabled
// - control bit 2 selects supply (0) or external input pin (1)
// - control bit 7 enables the detector; zero keeps it inactive
// - control bit 1 selects interrupt (0) or internal reset (1)
// - threshold register bits 3..0 choose the supply threshold code
// - writing zero to the whole control register stops the detector
// - clearing only the enable bit also stops the detector
// - every reset sets the interrupt mask to 1
// - disabling while below threshold raises a request and sets the flag
// - enabling may raise a request at once; software clears flag first
// - request flag is bit 0 of the low request register, cleared by software
// - in reset mode a hovering voltage may toggle reset repeatedly
// - interrupt on both falling below and returning above threshold
// - reset mode asserts internal reset while below threshold
// - threshold register survives detector reset, cleared by other resets
module lvdc_top
   import lvdc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   input  wire logic        DETECT_RESET,
   input  wire logic        CMP_ABOVE,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output var  logic        DETECTOR_ON,
   output var  logic        SOURCE_SELECT,
   output var  logic [3:0]  THRESHOLD_CODE,
   output var  logic        DETECT_IRQ_REQUEST,
   output var  logic        INTERNAL_RESET
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   lvdc_ctrl_s  ctrl_r, ctrl_nxt;
   logic [3:0]  thr_r, thr_nxt;
   logic        mask_r, mask_nxt;
   logic        flag_r, flag_nxt;
   logic        sync1_r, sync1_nxt;
   logic        sync2_r, sync2_nxt;
   logic        lvl_r, lvl_nxt;
   logic        irq_r, irq_nxt;
   logic        rst_out_r, rst_out_nxt;
   // axi write and read bookkeeping, then detector event strobes
   logic        awr_r, awr_nxt;
   logic        wr_r, wr_nxt;
   logic        bv_r, bv_nxt;
   logic [3:0]  awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic [3:0]  ws_r, ws_nxt;
   logic        ah_r, ah_nxt;
   logic        dh_r, dh_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        arr_r, arr_nxt;
   logic        rv_r, rv_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic        do_wr;
   logic        clr_flag;
   logic        cmp_event;
   logic        stop_event;
   logic        event_set;

   ////////////////////////////////////////////////////////////////////////////
   // comparator path: second flop only feeds later logic
   always_comb begin
      sync1_nxt = CMP_ABOVE;
      sync2_nxt = sync1_r;
      // a disabled detector rests at the above level
      lvl_nxt   = ctrl_r.enable ? sync2_r : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   always_comb begin
      ah_nxt  = ah_r;
      dh_nxt  = dh_r;
      awa_nxt = awa_r;
      wd_nxt  = wd_r;
      ws_nxt  = ws_r;
      bv_nxt  = bv_r;
      bresp_nxt = bresp_r;
      if (S_AXI_AWVALID && awr_r) begin
         ah_nxt  = 1'b1;
         awa_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wr_r) begin
         dh_nxt = 1'b1;
         wd_nxt = S_AXI_WDATA;
         ws_nxt = S_AXI_WSTRB;
      end
      // an unaligned address is answered with an error and changes nothing
      do_wr = ah_r && dh_r && !bv_r;
      if (do_wr) begin
         ah_nxt = 1'b0;
         dh_nxt = 1'b0;
         bv_nxt = 1'b1;
         bresp_nxt = (awa_r[1:0] == 2'b00) ? LVDC_RESP_OK : LVDC_RESP_ERR;
      end else if (bv_r && S_AXI_BREADY) begin
         bv_nxt = 1'b0;
      end
      // readies drop while a response waits, so one write at a time
      awr_nxt = !ah_nxt && !bv_nxt;
      wr_nxt  = !dh_nxt && !bv_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register updates and detector events
   always_comb begin
      ctrl_nxt = ctrl_r;
      thr_nxt  = thr_r;
      mask_nxt = mask_r;
      flag_nxt = flag_r;
      clr_flag = 1'b0;
      // only byte lane 0 carries register bits
      if (do_wr && ws_r[0]) begin
         unique case (awa_r)
            LVDC_CTRL_ADDR: begin
               // a full zero write and a lone enable clear both stop it
               ctrl_nxt.enable       = wd_r[LVDC_EN_BIT];
               ctrl_nxt.source_sel   = wd_r[LVDC_SRC_BIT];
               ctrl_nxt.response_sel = wd_r[LVDC_RESP_BIT];
            end
            LVDC_THR_ADDR:  thr_nxt  = wd_r[3:0];
            LVDC_IRQF_ADDR: clr_flag = !wd_r[0];
            LVDC_MASK_ADDR: mask_nxt = wd_r[0];
            default: ;
         endcase
      end
      // level change while enabled in interrupt mode, or disable while below threshold
      cmp_event  = !ctrl_r.response_sel && ctrl_r.enable && (sync2_r != lvl_r);
      stop_event = ctrl_r.enable && !ctrl_nxt.enable && !lvl_r;
      event_set  = cmp_event || stop_event;
      // set beats clear in the same cycle
      if (event_set) begin
         flag_nxt = 1'b1;
      end else if (clr_flag) begin
         flag_nxt = 1'b0;
      end
      irq_nxt     = event_set;
      // taken from the next control value so reset never outlives the enable
      rst_out_nxt = ctrl_nxt.enable && ctrl_nxt.response_sel && !sync2_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   always_comb begin
      arr_nxt = arr_r;
      rv_nxt  = rv_r;
      rd_nxt  = rd_r;
      rresp_nxt = rresp_r;
      if (S_AXI_ARVALID && arr_r) begin
         arr_nxt = 1'b0;
         rv_nxt  = 1'b1;
         rresp_nxt = LVDC_RESP_OK;
         rd_nxt  = 32'h0000_0000;
         unique case (S_AXI_ARADDR)
            LVDC_CTRL_ADDR: begin
               rd_nxt[LVDC_EN_BIT]   = ctrl_r.enable;
               rd_nxt[LVDC_SRC_BIT]  = ctrl_r.source_sel;
               rd_nxt[LVDC_RESP_BIT] = ctrl_r.response_sel;
               // compare flag reads 0 while disabled
               rd_nxt[LVDC_CMP_BIT]  = ctrl_r.enable & ~lvl_r;
            end
            LVDC_THR_ADDR:  rd_nxt[3:0] = thr_r;
            LVDC_IRQF_ADDR: rd_nxt[0]   = flag_r;
            LVDC_MASK_ADDR: rd_nxt[0]   = mask_r;
            default:        rresp_nxt   = LVDC_RESP_ERR;
         endcase
      end else if (rv_r && S_AXI_RREADY) begin
         // one read at a time; ready returns once the data is taken
         rv_nxt  = 1'b0;
         arr_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparator registers; reset to the idle above level, so no false edge
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         lvl_r   <= 1'b1;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         lvl_r   <= lvl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control, flag and event registers
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ctrl_r    <= '0;
         mask_r    <= LVDC_MASK_RST;
         flag_r    <= 1'b0;
         irq_r     <= 1'b0;
         rst_out_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         mask_r    <= mask_nxt;
         flag_r    <= flag_nxt;
         irq_r     <= irq_nxt;
         rst_out_r <= rst_out_nxt;
      end
   end

   // threshold: kept over a detector-caused reset, cleared by all others
   always_ff @(posedge SYS_CLK) begin
      if (SRST && !DETECT_RESET) begin
         thr_r <= LVDC_THR_RST;
      end else begin
         thr_r <= thr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write path registers
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         awr_r   <= 1'b1;
         wr_r    <= 1'b1;
         bv_r    <= 1'b0;
         awa_r   <= 4'h0;
         wd_r    <= 32'h0000_0000;
         ws_r    <= 4'h0;
         ah_r    <= 1'b0;
         dh_r    <= 1'b0;
         bresp_r <= LVDC_RESP_OK;
      end else begin
         awr_r   <= awr_nxt;
         wr_r    <= wr_nxt;
         bv_r    <= bv_nxt;
         awa_r   <= awa_nxt;
         wd_r    <= wd_nxt;
         ws_r    <= ws_nxt;
         ah_r    <= ah_nxt;
         dh_r    <= dh_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path registers
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         arr_r   <= 1'b1;
         rv_r    <= 1'b0;
         rd_r    <= 32'h0000_0000;
         rresp_r <= LVDC_RESP_OK;
      end else begin
         arr_r   <= arr_nxt;
         rv_r    <= rv_nxt;
         rd_r    <= rd_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   // the request pin is not masked; the mask is a readable bit only
   always_comb begin
      S_AXI_AWREADY      = awr_r;
      S_AXI_WREADY       = wr_r;
      S_AXI_BVALID       = bv_r;
      S_AXI_BRESP        = bresp_r;
      S_AXI_ARREADY      = arr_r;
      S_AXI_RVALID       = rv_r;
      S_AXI_RDATA        = rd_r;
      S_AXI_RRESP        = rresp_r;
      DETECTOR_ON        = ctrl_r.enable;
      SOURCE_SELECT      = ctrl_r.source_sel;
      THRESHOLD_CODE     = thr_r;
      DETECT_IRQ_REQUEST = irq_r;
      INTERNAL_RESET     = rst_out_r;
   end

endmodule : lvdc_top
`default_nettype wire

// [shared/lvdc_pkg.sv]
// package for the low-voltage detector control block
`default_nettype none
package lvdc_pkg;
   // register byte addresses on the AXI4-Lite bus
   localparam logic [3:0] LVDC_CTRL_ADDR   = 4'h0;
   localparam logic [3:0] LVDC_THR_ADDR    = 4'h4;
   localparam logic [3:0] LVDC_IRQF_ADDR   = 4'h8;
   localparam logic [3:0] LVDC_MASK_ADDR   = 4'hC;
   // detector control register fields
   localparam int LVDC_CMP_BIT  = 0;
   localparam int LVDC_RESP_BIT = 1;
   localparam int LVDC_SRC_BIT  = 2;
   localparam int LVDC_EN_BIT   = 7;
   // reset values
   localparam logic [7:0] LVDC_CTRL_RST = 8'h00;
   localparam logic [3:0] LVDC_THR_RST  = 4'h0;
   localparam logic       LVDC_MASK_RST = 1'b1;
   // AXI response codes
   localparam logic [1:0] LVDC_RESP_OK  = 2'b00;
   localparam logic [1:0] LVDC_RESP_ERR = 2'b10;
   // stabilization time, a longest time; 10 us at 125 MHz gives exactly 1250 cycles, no rounding
   localparam int LVDC_CLK_MHZ     = 125;
   localparam int LVDC_STAB_US     = 10;
   localparam int LVDC_STAB_CYCLES = LVDC_STAB_US * LVDC_CLK_MHZ;

   typedef struct packed {
      logic       enable;
      logic       source_sel;
      logic       response_sel;
   } lvdc_ctrl_s;
endpackage : lvdc_pkg
`default_nettype wire

// [sim/lvdc_top_checker.sv]
// port assertions for the low-voltage detector control block
`default_nettype none
module lvdc_top_checker
   import lvdc_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       SRST,
   input wire logic       DETECT_RESET,
   input wire logic       CMP_ABOVE,
   input wire logic       S_AXI_AWVALID,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WVALID,
   input wire logic       S_AXI_WREADY,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic       S_AXI_RVALID,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic       DETECTOR_ON,
   input wire logic [3:0] THRESHOLD_CODE,
   input wire logic       DETECT_IRQ_REQUEST,
   input wire logic       INTERNAL_RESET
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   // cycles with comparator and enable unchanged; 8 leaves room for the sync chain
   logic [3:0] quiet_r;
   always_ff @(posedge SYS_CLK) begin
      if (SRST || !$stable(CMP_ABOVE) || !$stable(DETECTOR_ON)) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
   end
   //////////////////////////////////////////////////////////////////////
   a_irq_single: assert property (DETECT_IRQ_REQUEST |=> !DETECT_IRQ_REQUEST)
      else $error("request pulse longer than one cycle");
   a_irq_cause: assert property (quiet_r >= 4'h8 && $stable(DETECTOR_ON) |-> !DETECT_IRQ_REQUEST)
      else $error("request without a comparator or enable change");
   a_rst_needs_on: assert property (INTERNAL_RESET |-> DETECTOR_ON)
      else $error("internal reset while detector off");
   a_rst_follows: assert property (INTERNAL_RESET && quiet_r >= 4'h8 |-> !CMP_ABOVE)
      else $error("internal reset held with voltage above threshold");
   a_idle_reset: assert property (disable iff (1'b0) SRST |=> !DETECTOR_ON && !DETECT_IRQ_REQUEST
      && !INTERNAL_RESET && !S_AXI_BVALID && !S_AXI_RVALID) else $error("outputs not idle after reset");
   a_thr_clear: assert property (disable iff (1'b0) SRST && !DETECT_RESET |=> THRESHOLD_CODE == 4'h0)
      else $error("threshold not cleared by reset");
   a_thr_keep: assert property (disable iff (1'b0) SRST && DETECT_RESET |=> $stable(THRESHOLD_CODE))
      else $error("threshold lost on detector reset");
   a_wr_lat: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   a_rd_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   c_irq: cover property (DETECT_IRQ_REQUEST);
   c_int_rst: cover property ($rose(INTERNAL_RESET));
   c_rd_err: cover property (S_AXI_RVALID && S_AXI_RRESP == LVDC_RESP_ERR);
endmodule : lvdc_top_checker
bind lvdc_top lvdc_top_checker chk (.*);
`default_nettype wire

// [sim/lvdc_cmp_model.sv]
// behavioural analog comparator in front of the detector
`default_nettype none
module lvdc_cmp_model (
   input  wire logic level_above,
   output wire logic cmp_above
);
   timeunit 1ns;
   timeprecision 1ps;
   // settles off the clock grid, so the sync chain sees a truly async edge
   assign #3 cmp_above = level_above;
endmodule : lvdc_cmp_model
`default_nettype wire

// [sim/tb_lvdc_top.sv]
// self-checking bench for the detector control block
`default_nettype none
module tb_lvdc_top import lvdc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, srst, dres, lvl, awvalid, wvalid, bready, arvalid, rready, src;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, seed, t;
   logic [7:0]  d;
   logic [1:0]  r;
   int          fails, samples_checked, n;
   wire logic   cmp, awready, wready, bvalid, arready, rvalid, det_on, src_sel, irq, int_rst;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [3:0]  thr;
   logic [7:0] rst_exp [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
   lvdc_cmp_model cmp_m (.level_above(lvl), .cmp_above(cmp));
   lvdc_top uut (.SYS_CLK(clk), .SRST(srst), .DETECT_RESET(dres), .CMP_ABOVE(cmp),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .DETECTOR_ON(det_on), .SOURCE_SELECT(src_sel), .THRESHOLD_CODE(thr),
      .DETECT_IRQ_REQUEST(irq), .INTERNAL_RESET(int_rst));
   //////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // bit 0 reads below-threshold only while enabled
   function automatic logic [7:0] ctrl_exp(logic en, logic s, logic rs, logic below);
      return {en, 4'h0, s, rs, en & below};
   endfunction : ctrl_exp
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(logic [3:0] a, logic [7:0] v, logic [1:0] er = LVDC_RESP_OK);
      @(posedge clk);
      awaddr <= a; wdata <= {24'h00_0000, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("bresp", {6'h00, bresp}, {6'h00, er});
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0; d = rdata[7:0]; r = rresp;
   endtask : rd
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   //////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1; dres = 1'b0; lvl = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000; wstrb = 4'hf; seed = 32'h484b_286a;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(4'(i * 4));
         check("reset value", d, rst_exp[i]);
      end
      rd(4'h2);
      check("unmapped read", {6'h00, r}, {6'h00, LVDC_RESP_ERR});
      repeat (4) begin
         t = xs();
         wr(LVDC_THR_ADDR, {4'h0, t[3:0]});
         rd(LVDC_THR_ADDR);
         check("threshold", d, {4'h0, t[3:0]});
         check("threshold pin", {4'h0, thr}, {4'h0, t[3:0]});
      end
      wstrb <= 4'h0;
      wr(LVDC_THR_ADDR, {4'h0, ~t[3:0]});
      wstrb <= 4'hf;
      wr(4'h5, {4'h0, ~t[3:0]}, LVDC_RESP_ERR);
      rd(LVDC_THR_ADDR);
      check("ignored writes", d, {4'h0, t[3:0]});
      $display("test registers done");
      src = t[4];
      wr(LVDC_CTRL_ADDR, ctrl_exp(1'b1, src, 1'b0, 1'b0));
      repeat (LVDC_STAB_CYCLES) @(posedge clk);
      rd(LVDC_CTRL_ADDR);
      check("control", d, ctrl_exp(1'b1, src, 1'b0, 1'b0));
      check("enable pins", {6'h00, det_on, src_sel}, {6'h00, 1'b1, src});
      wr(LVDC_IRQF_ADDR, 8'h00);
      wr(LVDC_MASK_ADDR, 8'h00);
      for (int k = 0; k < 2; k++) begin
         lvl <= 1'(k);
         n = 0;
         repeat (12) begin
            @(negedge clk);
            if (irq === 1'b1) n++;
         end
         check("irq pulses", 8'(n), 8'h01);
         rd(LVDC_IRQF_ADDR);
         check("irq flag set", d, 8'h01);
         rd(LVDC_CTRL_ADDR);
         check("compare flag", d, ctrl_exp(1'b1, src, 1'b0, ~1'(k)));
         wr(LVDC_IRQF_ADDR, 8'h00);
         rd(LVDC_IRQF_ADDR);
         check("irq flag clear", d, 8'h00);
      end
      $display("test interrupt mode done");
      wr(LVDC_CTRL_ADDR, ctrl_exp(1'b1, src, 1'b1, 1'b0));
      for (int k = 0; k < 2; k++) begin
         lvl <= 1'(k);
         repeat (8) @(negedge clk);
         check("internal reset", {7'h00, int_rst}, {7'h00, ~1'(k)});
         @(posedge clk);
      end
      $display("test reset mode done");
      for (int k = 0; k < 2; k++) begin
         wr(LVDC_CTRL_ADDR, ctrl_exp(1'b1, src, 1'b0, 1'b0));
         lvl <= 1'b0;
         repeat (12) @(posedge clk);
         wr(LVDC_IRQF_ADDR, 8'h00);
         wr(LVDC_CTRL_ADDR, k ? ctrl_exp(1'b0, src, 1'b0, 1'b0) : 8'h00);
         repeat (12) @(posedge clk);
         check("stopped", {7'h00, det_on}, 8'h00);
         rd(LVDC_IRQF_ADDR);
         check("stop event", d, 8'h01);
         lvl <= 1'b1;
      end
      $display("test stop done");
      srst <= 1'b1; dres <= 1'b1;
      @(posedge clk);
      srst <= 1'b0; dres <= 1'b0;
      rd(LVDC_THR_ADDR);
      check("threshold kept", d, {4'h0, t[3:0]});
      rd(LVDC_MASK_ADDR);
      check("mask after reset", d, 8'h01);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd(LVDC_THR_ADDR);
      check("threshold cleared", d, 8'h00);
      $display("test resets done");
      report_and_stop();
   end
endmodule : tb_lvdc_top
`default_nettype wire
